// ===== core/rps_consts.vh
// constants for the reset pin sequencer
`ifndef RPS_CONSTS_VH
`define RPS_CONSTS_VH

// core clock rate in mhz
`define RPS_CLK_MHZ 125
// processor reset hold time after release, in ns
`define RPS_CPU_RST_DELAY_NS 1000000
// processor reset hold time in core cycles, rounded down
`define RPS_CPU_RST_CYCLES ((`RPS_CPU_RST_DELAY_NS * `RPS_CLK_MHZ) / 1000)
// clocks from processor reset release to strap line release
`define RPS_STRAP_HOLD_CYCLES 2
// clocks from reset release to dram clock enable
`define RPS_CKE_DELAY_CYCLES 256
// core cycles per half period of the dram command clock
`define RPS_CMDCLK_HALF_CYCLES 2
// core cycles spent on impedance compensation after release
`define RPS_COMP_CYCLES 64
// sequencer states
`define RPS_ST_RESET 2'h0
`define RPS_ST_CPU_WAIT 2'h1
`define RPS_ST_STRAP_HOLD 2'h2
`define RPS_ST_RUN 2'h3

`endif

// ===== core/rps_seq.v
// reset pin sequencer: drives every interface pin state during and after hard reset
//
// Contract
// [R1] hard reset clears logic without a clock; code resets address, hub link and compensation logic only on clock edges
// [R2] power ok clears everything, sticky state included
// [R3] test select puts outputs in xor mode
// [R4] processor reset low, released 1ms after
// [R5] bus request driven low until two clocks after; code leaves it undriven in hard reset, drives it low from release
// [R6] strapped address lines released two clocks after
// [R7] dram command clocks low, toggle after release
// [R8] clock enable low, asserts after 256 clocks
// [R9] dram address level during reset is free
// [R10] legacy hub pulls then terminates low
// [R11] wide hub line16 pull follows swizzle
// [R12] calibration pins stay tri-stated throughout
// [R13] hub links timed by shared 66 mhz clock
// [R14] synchronise release before starting delay counters

`include "rps_consts.vh"

module rps_seq #(
	parameter ADDR_W = 33,                              // host address lines
	parameter LEG_W = 14,                               // legacy data 12 plus two strobes
	parameter WIDE_N = 3,                               // number of wide hub links
	parameter CAL_N = 4,                                // hub calibration pins
	parameter CPU_RST_CYCLES = `RPS_CPU_RST_CYCLES,     // 1 ms of core cycles
	parameter CKE_CYCLES = `RPS_CKE_DELAY_CYCLES,
	parameter COMP_CYCLES = `RPS_COMP_CYCLES
) (
	input wire i_clk,
	input wire i_rstn,
	input wire i_hard_reset_in_n,
	input wire i_power_ok_in,
	input wire i_board_test_select_n,
	input wire i_shared_hub_clock,
	input wire [ADDR_W-1:0] i_power_on_config,
	input wire [WIDE_N-1:0] i_wide_hub_swizzle,
	output reg o_processor_reset_out_n_o,
	output reg o_processor_reset_out_n_oe,
	output reg o_processor_bus_request_n_o,
	output reg o_processor_bus_request_n_oe,
	output reg [ADDR_W-1:0] o_host_address_lines_o,
	output reg [ADDR_W-1:0] o_host_address_lines_oe,
	output reg o_dram_command_clock,
	output reg o_dram_command_clock_n,
	output reg o_dram_clock_enable,
	output reg [14:0] o_dram_row_col_lines,
	output reg [LEG_W-1:0] o_legacy_hub_link_pu,
	output reg [LEG_W-1:0] o_legacy_hub_link_pd,
	output reg [LEG_W-1:0] o_legacy_hub_link_term_lo,
	output reg [WIDE_N-1:0] o_wide_hub_line16_pu,
	output reg [WIDE_N-1:0] o_wide_hub_line16_pd,
	output reg [WIDE_N-1:0] o_wide_hub_term_lo,
	output reg [CAL_N-1:0] o_hub_impedance_cal_pin_oe,
	output reg o_impedance_compensation_done,
	output reg o_xor_mode,
	output reg o_sticky_hard_reset_seen
);

	localparam LEG_LINE7 = 7;         // legacy line pulled up in reset

	// asynchronous clear from either reset pin
	wire arst = ~i_hard_reset_in_n | ~i_power_ok_in; // see [R1] see [R2]

	reg rel_meta_ff;                  // release synchroniser, first stage
	reg rel_ff;                       // release synchroniser, second stage
	reg [1:0] test_sync_ff;           // test select sync, two stages
	reg [2:0] hub_sync_ff;            // hub clock sync plus edge history
	reg [2*WIDE_N-1:0] swz_sync_ff;   // swizzle straps, two stages
	reg [1:0] st_ff;                  // sequencer state
	reg [1:0] nxt_st;
	reg [16:0] cnt_ff;                // processor reset and strap counter
	reg [16:0] nxt_cnt;
	reg [8:0] cke_cnt_ff;             // clock enable delay counter
	reg [7:0] comp_cnt_ff;            // compensation run counter
	reg [7:0] div_ff;                 // command clock divider
	reg hub_rel_ff;                   // hub side released on a hub edge
	reg ph_ff;                        // command clock phase

	wire test_on = ~test_sync_ff[1];                       // active low select
	wire hub_tick = hub_sync_ff[1] & ~hub_sync_ff[2];      // rising hub clock edge
	wire [WIDE_N-1:0] swz = swz_sync_ff[2*WIDE_N-1:WIDE_N];
	// xor chain over the sampled inputs for board test
	wire xor_val = ^{i_power_on_config, swz, hub_sync_ff[1]};
	wire div_tick = (div_ff == `RPS_CMDCLK_HALF_CYCLES - 1);

	// release synchroniser: clears at once, lets go on a clock edge
	always @(posedge i_clk or posedge arst) begin
		if (arst) begin
			rel_meta_ff <= 1'b0;     // see [R1]
			rel_ff <= 1'b0;
		end else begin
			rel_meta_ff <= i_rstn;   // see [R14]
			rel_ff <= rel_meta_ff;
		end
	end

	// two-flop synchronisers for the test select, hub clock and swizzle inputs
	always @(posedge i_clk) begin
		test_sync_ff <= {test_sync_ff[0], i_board_test_select_n};
		hub_sync_ff <= {hub_sync_ff[1:0], i_shared_hub_clock};
		swz_sync_ff <= {swz_sync_ff[WIDE_N-1:0], i_wide_hub_swizzle};
	end

	// sequencer next state
	always @* begin
		nxt_st = st_ff;
		nxt_cnt = cnt_ff;
		case (st_ff)
			`RPS_ST_RESET: begin
				nxt_st = `RPS_ST_CPU_WAIT;     // see [R14]
				nxt_cnt = 17'h0;
			end
			`RPS_ST_CPU_WAIT: begin
				// hold processor reset for the full delay
				if (cnt_ff == CPU_RST_CYCLES - 1) begin
					nxt_st = `RPS_ST_STRAP_HOLD;   // see [R4]
					nxt_cnt = 17'h0;
				end else begin
					nxt_cnt = cnt_ff + 17'h1;
				end
			end
			`RPS_ST_STRAP_HOLD: begin
				// two clocks after processor reset lets go
				if (cnt_ff == `RPS_STRAP_HOLD_CYCLES - 1) begin
					nxt_st = `RPS_ST_RUN;          // see [R5] see [R6]
				end else begin
					nxt_cnt = cnt_ff + 17'h1;
				end
			end
			default: begin
				nxt_st = `RPS_ST_RUN;
			end
		endcase
	end

	// pins that must react to hard reset without a clock
	always @(posedge i_clk or posedge arst) begin
		if (arst) begin
			st_ff <= `RPS_ST_RESET;
			cnt_ff <= 17'h0;
			o_processor_reset_out_n_o <= 1'b0;   // see [R4]
			o_processor_reset_out_n_oe <= 1'b1;
			o_processor_bus_request_n_o <= 1'b0;
			o_processor_bus_request_n_oe <= 1'b0; // see [R5]
			o_dram_command_clock <= 1'b0;        // see [R7]
			o_dram_command_clock_n <= 1'b0;
			o_dram_clock_enable <= 1'b0;         // see [R8]
			cke_cnt_ff <= 9'h0;
			div_ff <= 8'h0;
			ph_ff <= 1'b0;
		end else if (!rel_ff) begin
			// synchronous hold while release is not yet seen
			st_ff <= `RPS_ST_RESET;
			cnt_ff <= 17'h0;
			o_processor_reset_out_n_o <= test_on ? xor_val : 1'b0;
			o_processor_reset_out_n_oe <= 1'b1;
			o_processor_bus_request_n_o <= test_on ? xor_val : 1'b0;
			o_processor_bus_request_n_oe <= test_on;
			o_dram_command_clock <= test_on & xor_val;
			o_dram_command_clock_n <= test_on & xor_val;
			o_dram_clock_enable <= test_on & xor_val;
			cke_cnt_ff <= 9'h0;
			div_ff <= 8'h0;
			ph_ff <= 1'b0;
		end else begin
			st_ff <= nxt_st;
			cnt_ff <= nxt_cnt;
			// processor reset: driven low until the delay ends, then left to termination
			o_processor_reset_out_n_o <= test_on ? xor_val : 1'b0;
			o_processor_reset_out_n_oe <= test_on |
				(st_ff == `RPS_ST_RESET) | (st_ff == `RPS_ST_CPU_WAIT); // see [R4]
			// bus request driven low from release to end of strap hold
			o_processor_bus_request_n_o <= test_on ? xor_val : 1'b0;
			o_processor_bus_request_n_oe <= test_on | (st_ff != `RPS_ST_RUN); // see [R5]
			// command clock divider and both phases
			div_ff <= div_tick ? 8'h0 : div_ff + 8'h1;
			if (div_tick) begin
				ph_ff <= ~ph_ff;
			end
			o_dram_command_clock <= test_on ? xor_val : ph_ff;     // see [R7]
			o_dram_command_clock_n <= test_on ? xor_val : ~ph_ff;
			// clock enable after the fixed count
			if (cke_cnt_ff != CKE_CYCLES) begin
				cke_cnt_ff <= cke_cnt_ff + 9'h1;
			end
			o_dram_clock_enable <= test_on ? xor_val : (cke_cnt_ff == CKE_CYCLES); // see [R8]
		end
	end

	// pins that load strap or swizzle levels, clocked only
	always @(posedge i_clk) begin
		if (!rel_ff) begin
			// strapped address lines driven low while in reset
			o_host_address_lines_o <= test_on ? {ADDR_W{xor_val}} : {ADDR_W{1'b0}};
			o_host_address_lines_oe <= test_on ? {ADDR_W{1'b1}} : i_power_on_config; // see [R6]
			hub_rel_ff <= 1'b0;
			comp_cnt_ff <= 8'h0;
			o_impedance_compensation_done <= 1'b0;
		end else begin
			o_host_address_lines_o <= test_on ? {ADDR_W{xor_val}} : {ADDR_W{1'b0}};
			if (test_on) begin
				o_host_address_lines_oe <= {ADDR_W{1'b1}};
			end else if (st_ff == `RPS_ST_RUN) begin
				o_host_address_lines_oe <= {ADDR_W{1'b0}};  // see [R6]
			end
			// hub side leaves reset on a shared hub clock edge
			if (hub_tick) begin
				hub_rel_ff <= 1'b1;                          // see [R13]
			end
			// compensation runs once after release
			if (comp_cnt_ff != COMP_CYCLES) begin
				comp_cnt_ff <= comp_cnt_ff + 8'h1;
			end
			o_impedance_compensation_done <= (comp_cnt_ff == COMP_CYCLES);
		end
		// hub link pull and termination states
		if (test_on) begin
			o_legacy_hub_link_pu <= {LEG_W{1'b0}};
			o_legacy_hub_link_pd <= {LEG_W{1'b0}};
			o_legacy_hub_link_term_lo <= {LEG_W{xor_val}};
			o_wide_hub_line16_pu <= {WIDE_N{1'b0}};
			o_wide_hub_line16_pd <= {WIDE_N{1'b0}};
			o_wide_hub_term_lo <= {WIDE_N{xor_val}};
		end else if (!hub_rel_ff) begin
			// weak pulls, line 7 up and the rest down
			o_legacy_hub_link_pu <= {{(LEG_W-1){1'b0}}, 1'b1} << LEG_LINE7;   // see [R10]
			o_legacy_hub_link_pd <= ~({{(LEG_W-1){1'b0}}, 1'b1} << LEG_LINE7);
			o_legacy_hub_link_term_lo <= {LEG_W{1'b0}};
			o_wide_hub_line16_pu <= swz;                 // see [R11]
			o_wide_hub_line16_pd <= ~swz;
			o_wide_hub_term_lo <= {WIDE_N{1'b0}};
		end else begin
			o_legacy_hub_link_pu <= {LEG_W{1'b0}};
			o_legacy_hub_link_pd <= {LEG_W{1'b0}};
			o_legacy_hub_link_term_lo <= {LEG_W{1'b1}};  // see [R10]
			o_wide_hub_line16_pu <= {WIDE_N{1'b0}};
			o_wide_hub_line16_pd <= {WIDE_N{1'b0}};
			o_wide_hub_term_lo <= {WIDE_N{1'b1}};        // see [R11] see [R13]
		end
		// calibration pins never driven
		o_hub_impedance_cal_pin_oe <= {CAL_N{1'b0}};     // see [R12]
		// address lines carry no defined level, held at zero here
		o_dram_row_col_lines <= test_on ? {15{xor_val}} : 15'h0; // see [R9]
		o_xor_mode <= test_on;                           // see [R3]
	end

	// sticky record of a hard reset, cleared only by power ok
	always @(posedge i_clk or negedge i_power_ok_in) begin
		if (!i_power_ok_in) begin
			o_sticky_hard_reset_seen <= 1'b0;            // see [R2]
		end else if (!rel_ff && i_power_ok_in) begin
			o_sticky_hard_reset_seen <= 1'b1;
		end
	end

endmodule // rps_seq

// ===== bench/rps_seq_properties.sv
// concurrent checks on the reset pin sequencer ports
module rps_seq_chk #(
	parameter ADDR_W = 33,
	parameter CAL_N = 4,
	parameter CPU_RST_CYCLES = 20,
	parameter CKE_CYCLES = 256
) (
	input wire i_clk,
	input wire i_rstn,
	input wire i_hard_reset_in_n,
	input wire i_power_ok_in,
	input wire i_board_test_select_n,
	input wire o_processor_reset_out_n_oe,
	input wire o_processor_bus_request_n_oe,
	input wire [ADDR_W-1:0] o_host_address_lines_oe,
	input wire o_dram_command_clock,
	input wire o_dram_command_clock_n,
	input wire o_dram_clock_enable,
	input wire [CAL_N-1:0] o_hub_impedance_cal_pin_oe,
	input wire o_xor_mode,
	input wire o_sticky_hard_reset_seen
);
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_rstn);
	// edges seen with every reset inactive, saturating
	int cnt;
	always @(posedge i_clk) begin
		if (!i_rstn || !i_hard_reset_in_n || !i_power_ok_in) begin
			cnt <= 0;
		end else if (cnt < 1000000) begin
			cnt <= cnt + 1;
		end
	end
	wire nx = i_board_test_select_n && !o_xor_mode; // normal, not in test mode
	wire run = nx && i_hard_reset_in_n && i_power_ok_in; // normal and out of reset
	// only the release that ends the post-reset delay, not a test mode exit
	sequence s_cpu_free;
		run && cnt == CPU_RST_CYCLES + 4 && $fell(o_processor_reset_out_n_oe);
	endsequence
	sequence s_test_held;
		!i_board_test_select_n [*4];
	endsequence
	a_cpu_rst_hold: assert property (
		nx && !i_hard_reset_in_n |-> o_processor_reset_out_n_oe)
		else $error("processor reset not driven during hard reset");
	a_sticky_clear: assert property (
		!i_power_ok_in |-> !o_sticky_hard_reset_seen)
		else $error("sticky state survives power not ok");
	a_xor_entry: assert property (
		s_test_held |-> o_xor_mode)
		else $error("test select did not enter xor mode");
	a_cpu_release: assert property (
		run |-> o_processor_reset_out_n_oe == (cnt < CPU_RST_CYCLES + 4))
		else $error("processor reset released at wrong cycle");
	a_breq_hold: assert property (
		s_cpu_free |-> o_processor_bus_request_n_oe [*2] ##1 !o_processor_bus_request_n_oe)
		else $error("bus request not released two clocks later");
	a_strap_free: assert property (
		s_cpu_free |-> ##2 (o_host_address_lines_oe == '0))
		else $error("strapped address lines not released");
	a_clk_low: assert property (
		nx && !i_hard_reset_in_n |->
		!o_dram_command_clock && !o_dram_command_clock_n && !o_dram_clock_enable)
		else $error("dram clocks or enable active in reset");
	// two cycles of normal running needed so the history holds no xor values
	a_clk_toggle: assert property (
		run && $past(run, 2) && cnt >= 6 |->
		o_dram_command_clock != $past(o_dram_command_clock, 2) &&
		o_dram_command_clock == !o_dram_command_clock_n)
		else $error("dram command clock not toggling");
	a_cke_late: assert property (
		run |-> o_dram_clock_enable == (cnt >= CKE_CYCLES + 3))
		else $error("dram clock enable at wrong cycle");
	a_cal_tri: assert property (
		nx |-> o_hub_impedance_cal_pin_oe == '0)
		else $error("calibration pin driven");
endmodule // rps_seq_chk

bind rps_seq rps_seq_chk #(.ADDR_W(ADDR_W), .CAL_N(CAL_N), .CPU_RST_CYCLES(CPU_RST_CYCLES),
	.CKE_CYCLES(CKE_CYCLES)) u_chk (.*);

// ===== bench/rps_board_clk.sv
// board clock synthesizer model: free-running shared hub clock
module rps_board_clk (
	output logic o_hub_clk
);
	timeunit 1ns;
	timeprecision 1ps;
	// 66 mhz clock shared by every hub link, runs from power-up
	initial o_hub_clk = 1'b0;
	always #7.576 o_hub_clk = ~o_hub_clk;
endmodule // rps_board_clk

// ===== bench/tb.sv
// self-checking bench for the reset pin sequencer
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int CPU = 20; // shortened processor reset hold
	localparam int CKE = 16; // shortened clock-enable delay
	logic i_clk = 0, i_rstn = 0, i_hard_reset_in_n = 0, i_power_ok_in = 1;
	logic i_board_test_select_n = 1;
	logic [32:0] i_power_on_config = 33'h1000000a5;
	logic [2:0] i_wide_hub_swizzle = 3'h5;
	wire i_shared_hub_clock, o_processor_reset_out_n_o, o_processor_reset_out_n_oe;
	wire o_processor_bus_request_n_o, o_processor_bus_request_n_oe, o_dram_command_clock;
	wire o_dram_command_clock_n, o_dram_clock_enable, o_impedance_compensation_done;
	wire o_xor_mode, o_sticky_hard_reset_seen;
	wire [32:0] o_host_address_lines_o, o_host_address_lines_oe;
	wire [14:0] o_dram_row_col_lines;
	wire [13:0] o_legacy_hub_link_pu, o_legacy_hub_link_pd, o_legacy_hub_link_term_lo;
	wire [2:0] o_wide_hub_line16_pu, o_wide_hub_line16_pd, o_wide_hub_term_lo;
	wire [3:0] o_hub_impedance_cal_pin_oe;
	int err_total = 0, check_count = 0;
	always #4 i_clk = ~i_clk;
	rps_board_clk u_hub (.o_hub_clk(i_shared_hub_clock));
	rps_seq #(.CPU_RST_CYCLES(CPU), .CKE_CYCLES(CKE), .COMP_CYCLES(8)) dut (.*);
	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		check_count++;
		if (seen !== exp) begin
			err_total++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic end_sim;
		if (err_total == 0 && check_count > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	// pin states while hard reset is held
	task automatic t_in_reset;
		@(posedge i_clk);
		#1;
		chk({o_processor_reset_out_n_oe, o_processor_reset_out_n_o}, 2'h2);
		chk(o_processor_bus_request_n_oe, 0);
		chk(o_host_address_lines_oe, i_power_on_config);
		chk(o_host_address_lines_o, 0);
		chk({o_legacy_hub_link_pu, o_legacy_hub_link_pd}, {14'h0080, 14'h3f7f});
		chk({o_wide_hub_line16_pu, o_wide_hub_line16_pd}, {3'h5, 3'h2});
		chk(o_impedance_compensation_done, 0);
		chk(o_sticky_hard_reset_seen, 1);
	endtask
	// running sequence cut by a second hard reset, cleared before any clock edge
	task automatic t_abort;
		@(posedge i_clk) i_hard_reset_in_n <= 1'b1;
		repeat (CPU + 10) @(posedge i_clk);
		i_hard_reset_in_n <= 1'b0;
		#1;
		chk(o_processor_reset_out_n_oe, 1);
		chk({o_dram_command_clock, o_dram_command_clock_n}, 0);
		chk(o_dram_clock_enable, 0);
		repeat (4) @(posedge i_clk);
		t_in_reset();
	endtask
	// full release, timing clock enable, processor reset and bus request release from the releasing edge
	task automatic t_release;
		int t_cke, t_cpu, t_breq;
		t_cke = 0;
		t_cpu = 0;
		t_breq = 0;
		@(posedge i_clk) i_hard_reset_in_n <= 1'b1;
		for (int k = 1; k < 200 && t_breq == 0; k++) begin
			@(posedge i_clk);
			#1;
			if (k == 5) chk({o_processor_bus_request_n_oe, o_processor_bus_request_n_o}, 2'h2);
			if (k == 7) chk(o_dram_command_clock ^ o_dram_command_clock_n, 1);
			if (t_cke == 0 && o_dram_clock_enable === 1'b1) t_cke = k;
			if (t_cpu == 0 && o_processor_reset_out_n_oe === 1'b0) t_cpu = k;
			if (t_cpu != 0 && o_processor_bus_request_n_oe === 1'b0) t_breq = k;
		end
		if (t_breq == 0) begin
			err_total++;
			end_sim();
		end
		chk(t_cke, CKE + 3);
		chk(t_cpu, CPU + 4);
		chk(t_breq, CPU + 6);
		chk(o_host_address_lines_oe, 0);
		chk({o_legacy_hub_link_term_lo, o_legacy_hub_link_pu}, {14'h3fff, 14'h0});
		chk({o_legacy_hub_link_pd, o_wide_hub_line16_pd}, 0);
		chk({o_wide_hub_term_lo, o_wide_hub_line16_pu}, {3'h7, 3'h0});
		chk(o_hub_impedance_cal_pin_oe, 0);
		chk(o_impedance_compensation_done, 1);
	endtask
	// board test select enters and leaves xor mode
	task automatic t_xor;
		@(posedge i_clk) i_board_test_select_n <= 1'b0;
		repeat (5) @(posedge i_clk);
		#1;
		chk({o_xor_mode, o_hub_impedance_cal_pin_oe}, 5'h10);
		@(posedge i_clk) i_board_test_select_n <= 1'b1;
		repeat (5) @(posedge i_clk);
		#1;
		chk(o_xor_mode, 0);
	endtask
	// power not ok clears sticky state at once
	task automatic t_power;
		@(posedge i_clk) i_power_ok_in <= 1'b0;
		#1;
		chk({o_sticky_hard_reset_seen, o_processor_reset_out_n_oe}, 2'h1);
		repeat (3) @(posedge i_clk);
		i_power_ok_in <= 1'b1;
		repeat (4) @(posedge i_clk);
	endtask
	initial begin
		repeat (3) @(posedge i_clk);
		i_rstn <= 1'b1;
		repeat (4) @(posedge i_clk);
		t_in_reset();
		t_abort();
		t_release();
		t_xor();
		t_power();
		end_sim();
	end
endmodule // tb
